// ==== hdl/brg_map.vh ====
// constants for the programmable rate clock generator
`ifndef BRG_MAP_VH
`define BRG_MAP_VH
`define BRG_SEL_W      3
`define BRG_STAGES     7
`define BRG_ADDR_W     14
`define BRG_SEL_ADDR   14'h0040
`define BRG_UART_BASE  14'h0044
`define BRG_UART_MASK  14'h3ffe
`define BRG_CD_BIT     0
`define BRG_IO_CYCLE   1'h0
`define BRG_SEL_RESET  3'h0
`endif

// ==== hdl/brg_sync.v ====
// three-stage input synchroniser with second/third agreement
`timescale 1ns/1ps
module brg_sync
(
	// clock and reset
	input  wire mclk_in,
	input  wire rstn_in,
	// pin side
	input  wire pin_in,
	// clock domain side
	output wire level_out
);
	reg s1_ff;
	reg s2_ff;
	reg s3_ff;
	reg lvl_ff;
	always @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			s1_ff  <= 1'h0;
			s2_ff  <= 1'h0;
			s3_ff  <= 1'h0;
			lvl_ff <= 1'h0;
		end
		else
		begin
			s1_ff <= pin_in;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
			if (s2_ff == s3_ff)
				lvl_ff <= s3_ff;
		end
	end
	assign level_out = lvl_ff;
endmodule // brg_sync

// ==== hdl/brg_top.v ====
// programmable rate clock generator with host address decode
`timescale 1ns/1ps
`include "brg_map.vh"
module brg_top
#(
	parameter SEL_W   = `BRG_SEL_W,
	parameter STAGES  = `BRG_STAGES,
	parameter ADDR_W  = `BRG_ADDR_W
)
(
	// clock and reset
	input  wire              mclk_in,
	input  wire              rstn_in,
	// input rate clock pin
	input  wire              input_rate_clock_in,
	// host bus
	input  wire [ADDR_W-1:0] addr_in,
	input  wire              mem_io_in,
	input  wire [SEL_W-1:0]  rate_select_bits_in,
	// uart side
	output wire              rate_clock_out,
	output wire              rate_select_strobe_out,
	output wire              uart_cmd_data_out,
	output wire              uart_cs_n_out
);
	////////////////////////////////////////////////////////////////////////
	// one tap per divider stage plus the undivided input
	localparam TAPS = STAGES + 1;

	// synchronised input rate clock and its previous level
	wire              rclk_lvl;
	reg               rclk_prev_ff;
	reg               nxt_rclk_prev;
	// divider stages, their toggle enables and the tap bus
	reg  [STAGES-1:0] stage_ff;
	reg  [STAGES-1:0] nxt_stage;
	wire [STAGES-1:0] stage_en;
	wire [TAPS-1:0]   tap;
	// stored selection and strobe edge tracking
	reg  [SEL_W-1:0]  sel_ff;
	reg  [SEL_W-1:0]  nxt_sel;
	reg               strobe_prev_ff;
	reg               nxt_strobe_prev;
	wire              strobe_rise;
	// selected output clock
	reg               out_ff;
	reg               nxt_out;
	// address decode
	wire              io_cycle;
	wire              sel_match;
	wire              uart_match;
	wire              sel_hit;
	wire              uart_hit;

	////////////////////////////////////////////////////////////////////////
	// the input clock is asynchronous to mclk, so it is sampled first;
	// each level must last two mclk cycles or the sampler loses it
	brg_sync u_rclk_sync
	(
		.mclk_in   (mclk_in),
		.rstn_in   (rstn_in),
		.pin_in    (input_rate_clock_in),
		.level_out (rclk_lvl)
	);

	// previous level of the synchronised input, for edge detection
	always @*
	begin
		nxt_rclk_prev = rclk_lvl;
	end

	always @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			rclk_prev_ff <= 1'h0;
		end
		else
		begin
			rclk_prev_ff <= nxt_rclk_prev;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// toggle stage cascade
	// each stage toggles on the falling edge of the tap before it; done as
	// a synchronous enable so that no divided clock ever clocks a flop
	assign tap[0] = rclk_lvl;

	genvar gi;
	generate
		for (gi = 0; gi < STAGES; gi = gi + 1)
		begin : g_stage
			if (gi == 0)
			begin : g_first
				// first stage follows the synchronised input itself
				assign stage_en[gi] = ~rclk_lvl & rclk_prev_ff;
			end
			else
			begin : g_rest
				// the previous stage falls when it is enabled while high
				assign stage_en[gi] = stage_en[gi-1] & stage_ff[gi-1];
			end
			assign tap[gi+1] = stage_ff[gi];
		end
	endgenerate

	// every enabled stage flips, the rest hold
	always @*
	begin
		nxt_stage = stage_ff ^ stage_en;
	end

	// stages clear to zero so every tap starts low
	always @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			stage_ff <= {STAGES{1'h0}};
		end
		else
		begin
			stage_ff <= nxt_stage;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// address decode
	// combinational, so the strobe and the uart selects follow the
	// address and status with no added latency
	assign io_cycle   = (mem_io_in == `BRG_IO_CYCLE);
	assign sel_match  = (addr_in == `BRG_SEL_ADDR);
	assign uart_match = ((addr_in & `BRG_UART_MASK) == `BRG_UART_BASE);
	assign sel_hit    = io_cycle & sel_match;
	assign uart_hit   = io_cycle & uart_match;

	assign rate_select_strobe_out = sel_hit;
	// cmd/data is a plain address bit, meaningful whenever cs is low
	assign uart_cmd_data_out      = addr_in[`BRG_CD_BIT];
	assign uart_cs_n_out          = ~uart_hit;

	////////////////////////////////////////////////////////////////////////
	// taken on strobe rise only
	// data that changes while the strobe stays high is ignored, so a long
	// host cycle cannot smear a second value into the selection
	assign strobe_rise = sel_hit & ~strobe_prev_ff;

	// previous strobe level for the edge detect
	always @*
	begin
		nxt_strobe_prev = sel_hit;
	end

	always @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			strobe_prev_ff <= 1'h0;
		end
		else
		begin
			strobe_prev_ff <= nxt_strobe_prev;
		end
	end

	always @*
	begin
		if (strobe_rise)
		begin
			nxt_sel = rate_select_bits_in;
		end
		else
		begin
			nxt_sel = sel_ff;
		end
	end

	always @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			sel_ff <= `BRG_SEL_RESET;
		end
		else
		begin
			sel_ff <= nxt_sel;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// one tap to the output
	// code n picks tap n
	// registered so the mux never glitches the pin; a change of selection
	// may still cut one period of the old rate short
	always @*
	begin
		nxt_out = tap[sel_ff];
	end

	always @(posedge mclk_in or negedge rstn_in)
	begin
		if (!rstn_in)
		begin
			out_ff <= 1'h0;
		end
		else
		begin
			out_ff <= nxt_out;
		end
	end

	assign rate_clock_out = out_ff;
endmodule // brg_top

// ==== testbench/brg_top_props.sv ====
// checker for the decode outputs
`timescale 1ns/1ps
module brg_chk
(
	input logic        mclk_in,
	input logic        rstn_in,
	input logic [13:0] addr_in,
	input logic        mem_io_in,
	input logic        rate_clock_out,
	input logic        rate_select_strobe_out,
	input logic        uart_cmd_data_out,
	input logic        uart_cs_n_out
);
default clocking @(posedge mclk_in);
endclocking
default disable iff (!rstn_in);
strobe_decode_a: assert property (
	rate_select_strobe_out == (addr_in == 14'h0040 && !mem_io_in)) else $error("strobe decode");
cs_decode_a: assert property (
	uart_cs_n_out == !(addr_in[13:1] == 13'h0022 && !mem_io_in)) else $error("cs decode");
cmd_data_a: assert property (
	uart_cmd_data_out == addr_in[0]) else $error("cmd data");
strobe_cs_excl_a: assert property (
	rate_select_strobe_out |-> uart_cs_n_out) else $error("strobe and chip select together");
mem_cycle_quiet_a: assert property (
	mem_io_in |-> (!rate_select_strobe_out && uart_cs_n_out)) else $error("memory cycle decoded");
// a tap level lasts at least two cycles unless the selection just moved
high_width_a: assert property (
	$rose(rate_clock_out) && !$past(rate_select_strobe_out) && !$past(rate_select_strobe_out, 2)
	|=> rate_clock_out) else $error("rate clock high too short");
low_width_a: assert property (
	$fell(rate_clock_out) && !$past(rate_select_strobe_out) && !$past(rate_select_strobe_out, 2)
	|=> !rate_clock_out) else $error("rate clock low too short");
endmodule // brg_chk
bind brg_top brg_chk i_brg_chk(.*);

// ==== testbench/brg_uart_model.sv ====
// far side: times the rate clock in system cycles
`timescale 1ns/1ps
module brg_uart_model
(
	input  logic mclk_in,
	input  logic rate_clock_out,
	output int   period_out
);
int   count = 0;
logic last  = 0;
always @(posedge mclk_in)
begin
	last <= rate_clock_out;
	count <= count + 1;
	if (rate_clock_out && !last)
	begin
		period_out <= count + 1;
		count <= 0;
	end
end
endmodule // brg_uart_model

// ==== testbench/test_programmable_baud_rate_generator.sv ====
// self-checking bench for the rate clock generator
`timescale 1ns/1ps
`define CHK(n,e,s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
	$display("Error %s exp %0h got %0h", n, e, s); end end
module test_programmable_baud_rate_generator;
logic        mclk_in = 0, rstn_in = 0, input_rate_clock_in = 0, mem_io_in = 1;
logic [13:0] addr_in = 0;
logic [2:0]  rate_select_bits_in = 0;
wire         rate_clock_out, rate_select_strobe_out, uart_cmd_data_out, uart_cs_n_out;
int          period_out, bad_count = 0, checks_done = 0;
always #2.5 mclk_in = ~mclk_in;
// input clock period of 8 cycles keeps each level well above the sync depth
always
begin
	repeat (4) @(posedge mclk_in);
	input_rate_clock_in <= ~input_rate_clock_in;
end
brg_top i_brg_top(.*);
brg_uart_model i_brg_uart_model(.*);
task results;
	$display("checks %0d mismatches %0d", checks_done, bad_count);
	if (bad_count == 0 && checks_done > 0)
		$display("ALL TESTS PASSED");
	else
		$display("TESTS FAILED");
	$finish;
endtask
// code n gives period 8 << n
task test_rates;
	for (int n = 0; n < 8; n++)
	begin
		@(posedge mclk_in);
		addr_in <= 14'h0040;
		mem_io_in <= 0;
		rate_select_bits_in <= n[2:0];
		@(posedge mclk_in);
		addr_in <= 0;
		rate_select_bits_in <= ~n[2:0];
		repeat (24 << n) @(posedge mclk_in);
		`CHK("period", 8 << n, period_out)
	end
	$display("rates done");
endtask
// memory cycle must not write, uart select decode
task test_decode;
	@(posedge mclk_in);
	addr_in <= 14'h0040;
	mem_io_in <= 1;
	rate_select_bits_in <= 3'h5;
	#1 `CHK("strobe", 1'h0, rate_select_strobe_out)
	@(posedge mclk_in);
	addr_in <= 14'h0045;
	mem_io_in <= 0;
	#1 `CHK("cs", 1'h0, uart_cs_n_out)
	`CHK("cd", 1'h1, uart_cmd_data_out)
	repeat (2000) @(posedge mclk_in);
	`CHK("period", 1024, period_out)
	$display("decode done");
endtask
// a held strobe takes its data once; uart decode on both cycle kinds
task test_hold;
	@(posedge mclk_in);
	addr_in <= 14'h0040;
	mem_io_in <= 0;
	rate_select_bits_in <= 3'h3;
	@(posedge mclk_in);
	rate_select_bits_in <= 3'h6;
	#1 `CHK("strobe", 1'h1, rate_select_strobe_out)
	repeat (3) @(posedge mclk_in);
	addr_in <= 14'h0044;
	mem_io_in <= 1;
	#1 `CHK("cs", 1'h1, uart_cs_n_out)
	`CHK("cd", 1'h0, uart_cmd_data_out)
	@(posedge mclk_in);
	mem_io_in <= 0;
	#1 `CHK("cs", 1'h0, uart_cs_n_out)
	@(posedge mclk_in);
	addr_in <= 14'h0000;
	repeat (200) @(posedge mclk_in);
	`CHK("period", 64, period_out)
	$display("hold done");
endtask
// a reset mid-run clears the output and returns to the undivided rate
task test_reset;
	@(posedge mclk_in);
	rstn_in <= 0;
	addr_in <= 14'h0040;
	#1 `CHK("clock in reset", 1'h0, rate_clock_out)
	`CHK("strobe in reset", 1'h1, rate_select_strobe_out)
	repeat (5) @(posedge mclk_in);
	addr_in <= 14'h0000;
	@(posedge mclk_in);
	rstn_in <= 1;
	repeat (2)
	begin
		@(posedge mclk_in);
		#1 `CHK("clock after reset", 1'h0, rate_clock_out)
	end
	repeat (48) @(posedge mclk_in);
	`CHK("period", 8, period_out)
	$display("reset done");
endtask
initial
begin
	repeat (6) @(posedge mclk_in);
	rstn_in <= 1;
	test_rates;
	test_decode;
	test_hold;
	test_reset;
	results;
end
initial
begin
	// the scenarios need about 42 us; over twice that marks a hang
	#100us;
	bad_count++;
	results;
end
endmodule // test_programmable_baud_rate_generator
